// ### irqpf_pkg.sv
// shared constants, layouts and types for the interrupt flag register block
package irqpf_pkg;

  // avalon word addresses (byte address is four times these)
  localparam int unsigned      ADDR_W               = 3;
  localparam logic [2:0]       ADDR_RESET_CONTROL   = 3'h0;
  localparam logic [2:0]       ADDR_FLAGS_A         = 3'h1;
  localparam logic [2:0]       ADDR_FLAGS_B         = 3'h2;
  localparam logic [2:0]       ADDR_CONTROL         = 3'h3;
  localparam logic [2:0]       ADDR_IRQ_STATUS      = 3'h4;
  localparam logic [2:0]       ADDR_IRQ_MASK        = 3'h5;

  // reset_control field positions and values after reset
  localparam int unsigned      RC_PRIO_BIT          = 7;
  localparam int unsigned      RC_LONG_WRITE_ENABLE_BIT          = 6;
  localparam int unsigned      RC_UNUSED_BIT        = 5;
  localparam int unsigned      RC_CAUSE_W           = 5;
  localparam logic             RC_PRIO_RST          = 1'b0;
  localparam logic             RC_LONG_WRITE_ENABLE_RST          = 1'b0;
  localparam logic [4:0]       RC_CAUSE_RST         = 5'h1c;

  // peripheral_flags_a layout
  localparam int unsigned      FA_W                 = 8;
  localparam int unsigned      FA_PAR_PORT_BIT      = 7;
  localparam int unsigned      FA_CONV_BIT          = 6;
  localparam int unsigned      FA_RX_BIT            = 5;
  localparam int unsigned      FA_TX_BIT            = 4;
  localparam logic [7:0]       FA_WR_MASK           = 8'hcf;
  localparam logic [7:0]       FA_LEVEL_MASK        = 8'h30;
  localparam logic [7:0]       FA_RST               = 8'h00;

  // peripheral_flags_b layout, bits 7..4 read as zero
  localparam int unsigned      FB_W                 = 4;
  localparam logic [3:0]       FB_WR_MASK           = 4'hf;
  localparam logic [3:0]       FB_LEVEL_MASK        = 4'h0;
  localparam logic [3:0]       FB_RST               = 4'h0;

  // control register and interrupt status / mask
  localparam int unsigned      CTRL_PEG_BIT         = 0;
  localparam logic             CTRL_PEG_RST         = 1'b0;
  localparam int unsigned      IRQ_W                = 12;
  localparam logic [11:0]      IRQ_RST              = 12'h000;

  // events and levels from the peripherals
  typedef struct packed {
    logic par_port_access;
    logic conv_start;
    logic conv_done;
    logic rx_has_data;
    logic tx_empty;
    logic sync_serial;
    logic capture1;
    logic timer2_match;
    logic timer1_overflow;
    logic bus_collision;
    logic low_voltage;
    logic timer3_overflow;
    logic capture2;
  } irqpf_evt_type;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK  = 2'b10
  } irqpf_bus_state_type;

endpackage : irqpf_pkg

// ### irqpf_flag_bank.sv
// bank of event flags with hardware set, hardware clear and software write
`timescale 1ns/1ps
`default_nettype none
module irqpf_flag_bank #(
  parameter int unsigned W          = 8,
  parameter logic [W-1:0] LEVEL_MASK = '0,
  parameter logic [W-1:0] RST_VAL    = '0
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  // hardware side
  input  wire logic [W-1:0] set_i,
  input  wire logic [W-1:0] clr_i,
  // software side
  input  wire logic [W-1:0] wr_en_i,
  input  wire logic [W-1:0] wr_data_i,
  output logic      [W-1:0] flags_q
);

  // one flop per flag; set wins over any clear or write of zero
  for (genvar i = 0; i < W; i++) begin : g_bit
    if (LEVEL_MASK[i]) begin : g_level
      // read-only level bit just follows its source
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          flags_q[i] <= RST_VAL[i];
        end else begin
          flags_q[i] <= set_i[i];
        end
      end
    end else begin : g_sticky
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          flags_q[i] <= RST_VAL[i];
        end else if (set_i[i]) begin
          flags_q[i] <= 1'b1;
        end else if (wr_en_i[i]) begin
          flags_q[i] <= wr_data_i[i];
        end else if (clr_i[i]) begin
          flags_q[i] <= 1'b0;
        end
      end
    end
  end

endmodule : irqpf_flag_bank
`default_nettype wire

// ### irqpf_regs.sv
// reset-control and peripheral interrupt flag registers on an avalon slave
//
// How it works
// - top reset_control bit enables two priority levels
// - reset_control bit 5 reads zero, ignores writes
// - bits 4..0 hold five reset cause flags
// - parallel port access sets flags_a bit 7
// - flags_a holds eight flags, bit 7 to 0
// - flags set regardless of any enable bit
// - single level mode also needs peripheral group enable
// - receive flag follows receive buffer holding data
// - conversion flag zero until conversion finishes
//
// Local design decisions: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module irqpf_regs (
  // clock and reset
  input  wire logic                    clk_sys,
  input  wire logic                    nrst,
  // avalon-mm slave
  input  wire logic [2:0]              avs_address,
  input  wire logic                    avs_read,
  input  wire logic                    avs_write,
  input  wire logic [31:0]             avs_writedata,
  input  wire logic [3:0]              avs_byteenable,
  output logic      [31:0]             avs_readdata,
  output logic                         avs_waitrequest,
  // peripheral events and levels
  input  wire irqpf_pkg::irqpf_evt_type evt,
  // state seen by the rest of the chip
  output logic                         priority_levels_on,
  output logic                         long_write_enable,
  output logic                         peripheral_group_enable,
  output logic      [7:0]              peripheral_flags_a,
  output logic      [3:0]              peripheral_flags_b,
  output logic                         irq
);

  logic [1:0]                     rst_sync_q;
  logic                           rst_n;
  irqpf_pkg::irqpf_bus_state_type state_q;
  logic                           wait_q;
  logic [31:0]                    readdata_q;
  logic [31:0]                    rd_mux;
  logic                           rd_commit;
  logic                           wr_commit;
  logic                           wr_lo;
  logic                           wr_hi;
  logic                           prio_q;
  logic                           long_write_enable_q;
  logic [4:0]                     cause_q;
  logic                           peg_q;
  logic [7:0]                     flags_a_q;
  logic [3:0]                     flags_b_q;
  logic [7:0]                     set_a;
  logic [7:0]                     clr_a;
  logic [7:0]                     wr_en_a;
  logic [3:0]                     set_b;
  logic [3:0]                     wr_en_b;
  logic [11:0]                    flags_all;
  logic [11:0]                    prev_q;
  logic [11:0]                    status_q;
  logic [11:0]                    status_d;
  logic [11:0]                    mask_q;
  logic                           irq_q;

  // reset release through two flops, assertion stays asynchronous
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // a request commits on the edge where waitrequest is seen low
  assign rd_commit = avs_read & ~wait_q;
  assign wr_commit = avs_write & ~wait_q;
  assign wr_lo     = wr_commit & avs_byteenable[0];
  assign wr_hi     = wr_commit & avs_byteenable[1];

  // read mux; unmapped words read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (avs_address)
      irqpf_pkg::ADDR_RESET_CONTROL: begin
        rd_mux[7:0] = {prio_q, long_write_enable_q, 1'b0, cause_q};
      end
      irqpf_pkg::ADDR_FLAGS_A: begin
        rd_mux[7:0] = flags_a_q;
      end
      irqpf_pkg::ADDR_FLAGS_B: begin
        rd_mux[3:0] = flags_b_q;
      end
      irqpf_pkg::ADDR_CONTROL: begin
        rd_mux[irqpf_pkg::CTRL_PEG_BIT] = peg_q;
      end
      irqpf_pkg::ADDR_IRQ_STATUS: begin
        rd_mux[11:0] = status_q;
      end
      irqpf_pkg::ADDR_IRQ_MASK: begin
        rd_mux[11:0] = mask_q;
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  // bus handshake: one wait cycle, then one answer cycle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q    <= irqpf_pkg::BUS_IDLE;
      wait_q     <= 1'b1;
      readdata_q <= 32'h0000_0000;
    end else begin
      case (state_q)
        irqpf_pkg::BUS_IDLE: begin
          if (avs_read | avs_write) begin
            state_q    <= irqpf_pkg::BUS_ACK;
            wait_q     <= 1'b0;
            readdata_q <= rd_mux;
          end
        end
        irqpf_pkg::BUS_ACK: begin
          state_q <= irqpf_pkg::BUS_IDLE;
          wait_q  <= 1'b1;
        end
        default: begin
          state_q <= irqpf_pkg::BUS_IDLE;
          wait_q  <= 1'b1;
        end
      endcase
    end
  end
  assign avs_readdata    = readdata_q;
  assign avs_waitrequest = wait_q;

  // reset_control; cause bits are plain storage here, bit 5 has no flop
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      prio_q  <= irqpf_pkg::RC_PRIO_RST;
      long_write_enable_q  <= irqpf_pkg::RC_LONG_WRITE_ENABLE_RST;
      cause_q <= irqpf_pkg::RC_CAUSE_RST;
    end else if (wr_lo && avs_address == irqpf_pkg::ADDR_RESET_CONTROL) begin
      prio_q  <= avs_writedata[irqpf_pkg::RC_PRIO_BIT];
      long_write_enable_q  <= avs_writedata[irqpf_pkg::RC_LONG_WRITE_ENABLE_BIT];
      cause_q <= avs_writedata[4:0];
    end
  end

  // peripheral group enable lives in the control word
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      peg_q <= irqpf_pkg::CTRL_PEG_RST;
    end else if (wr_lo && avs_address == irqpf_pkg::ADDR_CONTROL) begin
      peg_q <= avs_writedata[irqpf_pkg::CTRL_PEG_BIT];
    end
  end

  // flag sources; enables are never consulted here so polling works
  assign set_a = {evt.par_port_access,
                  evt.conv_done,
                  evt.rx_has_data,
                  evt.tx_empty,
                  evt.sync_serial,
                  evt.capture1,
                  evt.timer2_match,
                  evt.timer1_overflow};
  // a new conversion drops the done flag until it finishes
  assign clr_a   = {1'b0, evt.conv_start, 6'h00};
  // only software can clear bit 7; hardware never does
  assign wr_en_a = {8{wr_lo && avs_address == irqpf_pkg::ADDR_FLAGS_A}}
                   & irqpf_pkg::FA_WR_MASK;
  assign set_b   = {evt.bus_collision, evt.low_voltage, evt.timer3_overflow, evt.capture2};
  assign wr_en_b = {4{wr_lo && avs_address == irqpf_pkg::ADDR_FLAGS_B}}
                   & irqpf_pkg::FB_WR_MASK;

  irqpf_flag_bank #(
    .W          (irqpf_pkg::FA_W),
    .LEVEL_MASK (irqpf_pkg::FA_LEVEL_MASK),
    .RST_VAL    (irqpf_pkg::FA_RST)
  ) u_flags_a (
    .clk_sys    (clk_sys),
    .rst_n      (rst_n),
    .set_i      (set_a),
    .clr_i      (clr_a),
    .wr_en_i    (wr_en_a),
    .wr_data_i  (avs_writedata[7:0]),
    .flags_q    (flags_a_q)
  );

  irqpf_flag_bank #(
    .W          (irqpf_pkg::FB_W),
    .LEVEL_MASK (irqpf_pkg::FB_LEVEL_MASK),
    .RST_VAL    (irqpf_pkg::FB_RST)
  ) u_flags_b (
    .clk_sys    (clk_sys),
    .rst_n      (rst_n),
    .set_i      (set_b),
    .clr_i      (4'h0),
    .wr_en_i    (wr_en_b),
    .wr_data_i  (avs_writedata[3:0]),
    .flags_q    (flags_b_q)
  );

  // rising flags become sticky status bits
  assign flags_all = {flags_b_q, flags_a_q};
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      prev_q <= irqpf_pkg::IRQ_RST;
    end else begin
      prev_q <= flags_all;
    end
  end

  // read clears only what that read reported, so late events survive
  always_comb begin
    status_d = status_q;
    if (rd_commit && avs_address == irqpf_pkg::ADDR_IRQ_STATUS) begin
      status_d = status_q & ~readdata_q[11:0];
    end
    status_d = status_d | (flags_all & ~prev_q);
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      status_q <= irqpf_pkg::IRQ_RST;
    end else begin
      status_q <= status_d;
    end
  end

  // mask written per byte lane
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mask_q <= irqpf_pkg::IRQ_RST;
    end else if (avs_address == irqpf_pkg::ADDR_IRQ_MASK) begin
      if (wr_lo) begin
        mask_q[7:0] <= avs_writedata[7:0];
      end
      if (wr_hi) begin
        mask_q[11:8] <= avs_writedata[11:8];
      end
    end
  end

  // level interrupt; in single level mode the group enable gates it
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= (|(status_q & mask_q)) & (prio_q | peg_q);
    end
  end

  assign priority_levels_on      = prio_q;
  assign long_write_enable       = long_write_enable_q;
  assign peripheral_group_enable = peg_q;
  assign peripheral_flags_a      = flags_a_q;
  assign peripheral_flags_b      = flags_b_q;
  assign irq                     = irq_q;

  // checks on the behaviour above
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_prio_bit_write: assert property (
    (wr_lo && avs_address == irqpf_pkg::ADDR_RESET_CONTROL)
      |=> (prio_q == $past(avs_writedata[7])))
    else $error("priority bit did not take written value");

  a_bit5_reads_zero: assert property (
    (rd_commit && avs_address == irqpf_pkg::ADDR_RESET_CONTROL) |-> !avs_readdata[5])
    else $error("reset_control bit 5 read as one");

  a_cause_reset_val: assert property (
    $rose(rst_n) |-> (cause_q == irqpf_pkg::RC_CAUSE_RST))
    else $error("reset cause bits wrong after reset");

  a_par_port_set: assert property (
    evt.par_port_access |=> flags_a_q[7]
      ##1 (flags_a_q[7] || $past(wr_en_a[7] && !avs_writedata[7])))
    else $error("parallel port flag not set and held");

  a_status_no_enable: assert property (
    (flags_a_q[0] && !prev_q[0]) |=> status_q[0])
    else $error("status missed a flag rise");

  a_irq_group_gate: assert property (
    (!prio_q && !peg_q) |=> !irq_q)
    else $error("interrupt raised without group enable");

  a_rx_follow_level: assert property (
    ##1 (flags_a_q[5] == $past(evt.rx_has_data)))
    else $error("receive flag does not follow buffer level");

  a_conv_start_clear: assert property (
    (evt.conv_start && !evt.conv_done && !wr_en_a[6]) |=> !flags_a_q[6])
    else $error("conversion flag not cleared at start");

  a_set_beats_clear: assert property (
    (wr_en_a[0] && !avs_writedata[0] && evt.timer1_overflow) |=> flags_a_q[0])
    else $error("software clear beat hardware set");

  a_wait_one_cycle: assert property (
    ((avs_read || avs_write) && wait_q) |=> !wait_q ##1 wait_q)
    else $error("bus answer not one cycle after request");

  c_status_read: cover property (rd_commit && avs_address == irqpf_pkg::ADDR_IRQ_STATUS
                                 && avs_readdata[11:0] != 12'h000);
  c_irq_raised: cover property ($rose(irq_q));
  c_set_vs_clear: cover property (wr_en_a[7] && evt.par_port_access);
  c_prio_on: cover property ($rose(prio_q));

endmodule : irqpf_regs
`default_nettype wire

// ### tb_top.sv
// self-checking bench for the interrupt flag register block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic                     clk_sys;
  logic                     nrst;
  logic [2:0]               avs_address;
  logic                     avs_read;
  logic                     avs_write;
  logic [31:0]              avs_writedata;
  logic [3:0]               avs_byteenable;
  logic [31:0]              avs_readdata;
  logic                     avs_waitrequest;
  irqpf_pkg::irqpf_evt_type ev;
  logic                     priority_levels_on;
  logic                     long_write_enable;
  logic                     peripheral_group_enable;
  logic [7:0]               peripheral_flags_a;
  logic [3:0]               peripheral_flags_b;
  logic                     irq;
  logic [12:0]              lvl;
  logic [31:0]              q;
  int                       fail_count;
  int                       checks_done;
  int                       fa_m;
  int                       m_rc;
  int                       m_fa;
  int                       m_fb;
  int                       exp_q[$];
  int                       ev_a[6] = '{12, 10, 7, 6, 5, 4};
  int                       bit_a[6] = '{7, 6, 3, 2, 1, 0};

  irqpf_regs dut (
    .clk_sys(clk_sys), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .evt(ev),
    .priority_levels_on(priority_levels_on), .long_write_enable(long_write_enable),
    .peripheral_group_enable(peripheral_group_enable), .peripheral_flags_a(peripheral_flags_a),
    .peripheral_flags_b(peripheral_flags_b), .irq(irq)
  );

  // 50 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // one avalon access; request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [2:0] a, input logic [31:0] d,
                     input logic [3:0] be, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk_sys);
    avs_address    <= a;
    avs_writedata  <= d;
    avs_byteenable <= be;
    avs_write      <= wr;
    avs_read       <= !wr;
    // values read right after the edge are those the slave showed at that edge
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (avs_waitrequest !== 1'b0) begin
      fail_count++;
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask : bus

  task automatic wr(input logic [2:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    bus(1'b1, a, d, 4'hf, dummy);
  endtask : wr

  // write that also updates the model of the software-visible bits
  task automatic wr_m(input logic [2:0] a, input int d);
    wr(a, d);
    if (a == irqpf_pkg::ADDR_RESET_CONTROL) begin
      m_rc = d & 32'hdf;
    end else if (a == irqpf_pkg::ADDR_FLAGS_A) begin
      m_fa = d & 32'hcf;
    end else if (a == irqpf_pkg::ADDR_FLAGS_B) begin
      m_fb = d & 32'hf;
    end
  endtask : wr_m

  // expected values queue up in order, the read answer takes the oldest
  task automatic rdchk(input logic [2:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    exp_q.push_back(exp);
    bus(1'b0, a, 32'h0, 4'hf, rd);
    chk(rd, exp_q.pop_front());
  endtask : rdchk

  task automatic idle(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : idle

  // one-cycle event pulse on top of the standing levels
  task automatic pulse(input logic [12:0] b);
    @(posedge clk_sys);
    ev <= irqpf_pkg::irqpf_evt_type'(b | lvl);
    @(posedge clk_sys);
    ev <= irqpf_pkg::irqpf_evt_type'(lvl);
    idle(2);
  endtask : pulse

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : finish_test

  // watchdog: the whole run needs about five hundred cycles
  initial begin
    #400000;
    fail_count++;
    finish_test();
  end

  initial begin
    fail_count = 0;
    checks_done = 0;
    m_rc = 0;
    m_fa = 0;
    m_fb = 0;
    lvl = 13'h0;
    ev = '0;
    nrst = 1'b0;
    avs_address = 3'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    void'($urandom(69460));
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    // reset values and unmapped places; an unmapped write is answered and dropped
    rdchk(irqpf_pkg::ADDR_RESET_CONTROL, 32'h1c);
    rdchk(irqpf_pkg::ADDR_FLAGS_A, 32'h0);
    rdchk(irqpf_pkg::ADDR_FLAGS_B, 32'h0);
    rdchk(3'h6, 32'h0);
    wr(3'h7, 32'hff);
    rdchk(3'h7, 32'h0);
    chk(irq, 1'b0);
    $display("test reset values done");
    // reset_control access kinds
    wr(irqpf_pkg::ADDR_RESET_CONTROL, 32'hff);
    rdchk(irqpf_pkg::ADDR_RESET_CONTROL, 32'hdf);
    chk(priority_levels_on, 1'b1);
    chk(long_write_enable, 1'b1);
    bus(1'b1, irqpf_pkg::ADDR_RESET_CONTROL, 32'h0, 4'h0, q);
    rdchk(irqpf_pkg::ADDR_RESET_CONTROL, 32'hdf);
    wr(irqpf_pkg::ADDR_RESET_CONTROL, 32'h0);
    rdchk(irqpf_pkg::ADDR_RESET_CONTROL, 32'h0);
    chk(priority_levels_on, 1'b0);
    $display("test reset control done");
    // each event sets its own flag, no enable needed
    fa_m = 0;
    for (int i = 0; i < 6; i++) begin
      pulse(13'h1 << ev_a[i]);
      fa_m = fa_m | (1 << bit_a[i]);
      chk(peripheral_flags_a, fa_m[7:0]);
    end
    for (int i = 0; i < 4; i++) begin
      pulse(13'h1 << i);
      chk(peripheral_flags_b, (1 << (i + 1)) - 1);
    end
    idle(10);
    rdchk(irqpf_pkg::ADDR_FLAGS_A, 32'hcf);
    rdchk(irqpf_pkg::ADDR_FLAGS_B, 32'hf);
    pulse(13'h800);
    chk(peripheral_flags_a, 8'h8f);
    pulse(13'h400);
    chk(peripheral_flags_a, 8'hcf);
    $display("test event flags done");
    // receive and transmit levels, read-only under writes
    lvl = 13'h300;
    pulse(13'h0);
    chk(peripheral_flags_a, 8'hff);
    wr(irqpf_pkg::ADDR_FLAGS_A, 32'h0);
    rdchk(irqpf_pkg::ADDR_FLAGS_A, 32'h30);
    lvl = 13'h0;
    pulse(13'h0);
    chk(peripheral_flags_a, 8'h0);
    // hardware set held across a software clear wins; look once the write has landed
    lvl = 13'h010;
    pulse(13'h0);
    wr(irqpf_pkg::ADDR_FLAGS_A, 32'h0);
    idle(1);
    chk(peripheral_flags_a, 8'h01);
    lvl = 13'h0;
    pulse(13'h0);
    wr(irqpf_pkg::ADDR_FLAGS_A, 32'h08);
    rdchk(irqpf_pkg::ADDR_FLAGS_A, 32'h08);
    $display("test write priority done");
    // interrupt: mask, group enable, priority mode, clear on status read
    wr(irqpf_pkg::ADDR_FLAGS_A, 32'h0);
    wr(irqpf_pkg::ADDR_FLAGS_B, 32'h0);
    bus(1'b1, irqpf_pkg::ADDR_IRQ_MASK, 32'h1, 4'h3, q);
    rdchk(irqpf_pkg::ADDR_IRQ_MASK, 32'h001);
    bus(1'b0, irqpf_pkg::ADDR_IRQ_STATUS, 32'h0, 4'hf, q);
    rdchk(irqpf_pkg::ADDR_IRQ_STATUS, 32'h000);
    pulse(13'h010);
    idle(3);
    chk(irq, 1'b0);
    wr(irqpf_pkg::ADDR_CONTROL, 32'h1);
    idle(3);
    chk(peripheral_group_enable, 1'b1);
    chk(irq, 1'b1);
    rdchk(irqpf_pkg::ADDR_CONTROL, 32'h1);
    rdchk(irqpf_pkg::ADDR_IRQ_STATUS, 32'h001);
    idle(3);
    chk(irq, 1'b0);
    wr(irqpf_pkg::ADDR_CONTROL, 32'h0);
    wr(irqpf_pkg::ADDR_RESET_CONTROL, 32'h80);
    wr(irqpf_pkg::ADDR_FLAGS_A, 32'h0);
    pulse(13'h010);
    idle(3);
    chk(irq, 1'b1);
    bus(1'b1, irqpf_pkg::ADDR_IRQ_MASK, 32'h0, 4'h3, q);
    idle(3);
    chk(irq, 1'b0);
    $display("test interrupt done");
    // random writes against the bit-access model
    for (int i = 0; i < 16; i++) begin
      fa_m = $urandom;
      wr_m(irqpf_pkg::ADDR_FLAGS_A, fa_m);
      wr_m(irqpf_pkg::ADDR_RESET_CONTROL, $urandom);
      wr_m(irqpf_pkg::ADDR_FLAGS_B, $urandom);
      rdchk(irqpf_pkg::ADDR_FLAGS_A, m_fa);
      rdchk(irqpf_pkg::ADDR_RESET_CONTROL, m_rc);
      rdchk(irqpf_pkg::ADDR_FLAGS_B, m_fb);
      chk(priority_levels_on, m_rc[7]);
    end
    $display("test random access done");
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
